// ===== verilog/byte_op_instruction_decoder.v
// Instruction decoder that sequences one- and two-word instructions.
`timescale 1ns/100ps
`include "byte_op_decoder_consts.vh"
// What this block does
// - Destination bit picks working register or file.
// - Access bit forces access bank or bank select.
// - File address is the low instruction byte.
// - File-to-file move uses two words, 12-bit addresses.
// - Bit operations carry a 3-bit bit position.
// - Literal operand is the low instruction byte.
// - Call and jump target is 20 bits over two words.
// - Branch offsets are 11 bits or 8 bits.
// - Taken or PC-changing instruction adds a no-op cycle.
// - Unused second word executes as a no-op.
// - Port self-modify reads pins, not latches.
// - Byte-op and bit-op writes to timer zero count clear its prescaler.
// - Add forms decode and update five flags.
// - Subtract forms decode and update five flags.
// - Logic group updates only zero and negative.
// - Step-and-skip forms leave flags unchanged.
// - Compare-and-skip forms leave flags unchanged.
// - Rotates decode with their flag sets.
// - Multiply takes one cycle, flags unchanged.
module byte_op_instruction_decoder #(
   parameter WORD_W = `WORD_W
) (
   input wire CLOCK_IN,
   input wire RESETN_IN,
   input wire WORD_VALID_IN,
   input wire [WORD_W-1:0] WORD_IN,
   input wire SKIP_TAKEN_IN,
   input wire BRANCH_TAKEN_IN,
   input wire [`BANK_W-1:0] BANK_SELECT_IN,
   input wire TIMER_ZERO_COUNT_PRESCALER_ASSIGNED_IN,
   input wire [`FILE_ADDR_W-1:0] PORT_ADDR_LO_IN,
   input wire [`FILE_ADDR_W-1:0] PORT_ADDR_HI_IN,
   output reg [4:0] OP_OUT,
   output reg OP_VALID_OUT,
   output reg NOP_CYCLE_OUT,
   output reg DEST_FILE_OUT,
   output reg [`BANK_W-1:0] BANK_OUT,
   output reg [`FILE_ADDR_W-1:0] FILE_ADDR_OUT,
   output reg [`BIT_POS_W-1:0] BIT_POS_OUT,
   output reg [`LIT_W-1:0] LITERAL_OUT,
   output reg [`WIDE_ADDR_W-1:0] MOVE_SRC_OUT,
   output reg [`WIDE_ADDR_W-1:0] MOVE_DST_OUT,
   output reg [`TARGET_W-1:0] TARGET_OUT,
   output reg [`BRA_OFS_W-1:0] BRANCH_OFS_OUT,
   output reg [`FLAGS_W-1:0] FLAGS_AFFECTED_OUT,
   output reg READ_PINS_OUT,
   output reg PRESCALER_CLEAR_OUT,
   output reg BUSY_OUT
);
   localparam ST_FETCH = 2'h0;
   localparam ST_SECOND = 2'h1;
   localparam ST_NOP = 2'h2;
   localparam ST_SKIP2 = 2'h3;

   wire [4:0] cls_op;
   wire [`FLAGS_W-1:0] cls_flags;
   wire cls_dest;
   wire cls_two;
   wire cls_skip;
   wire cls_pcmod;
   wire cls_wr;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [4:0] pend_op_ff;
   reg [4:0] nxt_pend_op;
   reg [`FILE_ADDR_W-1:0] lo_byte_ff;
   reg [`FILE_ADDR_W-1:0] nxt_lo_byte;
   reg [`WIDE_ADDR_W-1:0] src_ff;
   reg [`WIDE_ADDR_W-1:0] nxt_src;
   reg skip_armed_ff;
   reg nxt_skip_armed;
   reg fetch_take;
   reg port_hit;

   opcode_classifier u_classifier (
      .word_in(WORD_IN),
      .op_out(cls_op),
      .flags_out(cls_flags),
      .has_dest_out(cls_dest),
      .two_word_out(cls_two),
      .is_skip_out(cls_skip),
      .pc_mod_out(cls_pcmod),
      .writes_file_out(cls_wr)
   );

   // Port range check kept as a function since both bounds are compared.
   function in_port_range;
      input [`FILE_ADDR_W-1:0] addr;
      input [`FILE_ADDR_W-1:0] lo;
      input [`FILE_ADDR_W-1:0] hi;
      begin
         in_port_range = (addr >= lo) && (addr <= hi);
      end
   endfunction

   always @* begin
      nxt_state = state_ff;
      nxt_pend_op = pend_op_ff;
      nxt_lo_byte = lo_byte_ff;
      nxt_src = src_ff;
      nxt_skip_armed = skip_armed_ff;
      fetch_take = 1'b0;
      port_hit = in_port_range(WORD_IN[`FILE_ADDR_W-1:0],
         PORT_ADDR_LO_IN, PORT_ADDR_HI_IN);
      case (state_ff)
         ST_FETCH: begin
            if (WORD_VALID_IN) begin
               if (skip_armed_ff) begin
                  // The skipped word is dropped; a two-word one costs one more.
                  nxt_skip_armed = 1'b0;
                  nxt_state = cls_two ? ST_SKIP2 : ST_FETCH;
               end else begin
                  fetch_take = 1'b1;
                  nxt_pend_op = cls_op;
                  nxt_lo_byte = WORD_IN[`FILE_ADDR_W-1:0];
                  nxt_src = WORD_IN[`WIDE_ADDR_W-1:0];
                  if (cls_two) begin
                     nxt_state = ST_SECOND;
                  end else if (cls_pcmod ||
                     (cls_op == `OP_CBR && BRANCH_TAKEN_IN)) begin
                     nxt_state = ST_NOP;
                  end
               end
            end
         end
         ST_SECOND: begin
            if (WORD_VALID_IN) begin
               nxt_state = (pend_op_ff == `OP_CALL ||
                  pend_op_ff == `OP_GOTO) ? ST_NOP : ST_FETCH;
            end
         end
         ST_NOP: nxt_state = ST_FETCH;
         ST_SKIP2: begin
            if (WORD_VALID_IN) begin
               nxt_state = ST_FETCH;
            end
         end
         default: nxt_state = ST_FETCH;
      endcase
      // A skip outcome arrives in the same cycle as the skip instruction word.
      if (SKIP_TAKEN_IN && state_ff == ST_FETCH && !skip_armed_ff &&
         WORD_VALID_IN && cls_skip) begin
         nxt_skip_armed = 1'b1;
      end
   end

   always @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_ff <= ST_FETCH;
         pend_op_ff <= `OP_NONE;
         lo_byte_ff <= {`FILE_ADDR_W{1'b0}};
         src_ff <= {`WIDE_ADDR_W{1'b0}};
         skip_armed_ff <= 1'b0;
         OP_OUT <= `OP_NONE;
         OP_VALID_OUT <= 1'b0;
         NOP_CYCLE_OUT <= 1'b0;
         DEST_FILE_OUT <= 1'b0;
         BANK_OUT <= `ACCESS_BANK;
         FILE_ADDR_OUT <= {`FILE_ADDR_W{1'b0}};
         BIT_POS_OUT <= {`BIT_POS_W{1'b0}};
         LITERAL_OUT <= {`LIT_W{1'b0}};
         MOVE_SRC_OUT <= {`WIDE_ADDR_W{1'b0}};
         MOVE_DST_OUT <= {`WIDE_ADDR_W{1'b0}};
         TARGET_OUT <= {`TARGET_W{1'b0}};
         BRANCH_OFS_OUT <= {`BRA_OFS_W{1'b0}};
         FLAGS_AFFECTED_OUT <= {`FLAGS_W{1'b0}};
         READ_PINS_OUT <= 1'b0;
         PRESCALER_CLEAR_OUT <= 1'b0;
         BUSY_OUT <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pend_op_ff <= nxt_pend_op;
         lo_byte_ff <= nxt_lo_byte;
         src_ff <= nxt_src;
         skip_armed_ff <= nxt_skip_armed;
         OP_VALID_OUT <= 1'b0;
         NOP_CYCLE_OUT <= 1'b0;
         PRESCALER_CLEAR_OUT <= 1'b0;
         READ_PINS_OUT <= 1'b0;
         BUSY_OUT <= (nxt_state != ST_FETCH) || nxt_skip_armed;
         if (fetch_take && !cls_two) begin
            OP_OUT <= cls_op;
            OP_VALID_OUT <= 1'b1;
            FLAGS_AFFECTED_OUT <= cls_flags;
            DEST_FILE_OUT <= cls_dest ? WORD_IN[9] :
               (cls_op == `OP_BITOP);
            BANK_OUT <= WORD_IN[8] ? BANK_SELECT_IN : `ACCESS_BANK;
            FILE_ADDR_OUT <= WORD_IN[`FILE_ADDR_W-1:0];
            BIT_POS_OUT <= WORD_IN[11:9];
            LITERAL_OUT <= WORD_IN[`LIT_W-1:0];
            BRANCH_OFS_OUT <= (cls_op == `OP_BRA) ?
               WORD_IN[`BRA_OFS_W-1:0] :
               {{(`BRA_OFS_W-`BR_OFS_W){WORD_IN[7]}},
               WORD_IN[`BR_OFS_W-1:0]};
            // Self-modify of a port must see pin levels, not the latch.
            // With the result sent to the working register the port is
            // not written back, so the latch is left as the source.
            READ_PINS_OUT <= cls_wr && port_hit &&
               (cls_op == `OP_BITOP || (cls_dest && WORD_IN[9]));
            PRESCALER_CLEAR_OUT <= TIMER_ZERO_COUNT_PRESCALER_ASSIGNED_IN &&
               WORD_IN[`FILE_ADDR_W-1:0] == `TIMER_ZERO_COUNT_ADDR &&
               (cls_op == `OP_BITOP || (cls_dest && WORD_IN[9]));
         end else if (state_ff == ST_SECOND && WORD_VALID_IN) begin
            OP_OUT <= pend_op_ff;
            OP_VALID_OUT <= (pend_op_ff != `OP_NONE);
            NOP_CYCLE_OUT <= (pend_op_ff == `OP_NONE);
            FLAGS_AFFECTED_OUT <= {`FLAGS_W{1'b0}};
            MOVE_SRC_OUT <= src_ff;
            MOVE_DST_OUT <= WORD_IN[`WIDE_ADDR_W-1:0];
            TARGET_OUT <= {WORD_IN[`WIDE_ADDR_W-1:0], lo_byte_ff};
            LITERAL_OUT <= WORD_IN[`LIT_W-1:0];
         end else if (state_ff == ST_NOP ||
            (state_ff == ST_FETCH && WORD_VALID_IN && skip_armed_ff) ||
            (state_ff == ST_SKIP2 && WORD_VALID_IN)) begin
            // A no-op cycle leaves the datapath idle and the flags alone.
            NOP_CYCLE_OUT <= 1'b1;
            FLAGS_AFFECTED_OUT <= {`FLAGS_W{1'b0}};
         end
      end
   end
endmodule // byte_op_instruction_decoder

// ===== verilog/byte_op_decoder_consts.vh
// Constants for the byte-operation instruction decoder.
`ifndef BYTE_OP_DECODER_CONSTS_VH
`define BYTE_OP_DECODER_CONSTS_VH
`define WORD_W 16
`define FILE_ADDR_W 8
`define WIDE_ADDR_W 12
`define TARGET_W 20
`define BIT_POS_W 3
`define BRA_OFS_W 11
`define BR_OFS_W 8
`define LIT_W 8
`define OPC_FILE_TO_FILE_MOVE_FIRST 4'hc
`define OPC_SECOND_WORD 4'hf
`define OPC_BRA 5'h1a
`define OPC_COND_BR 5'h1c
`define OPC_CALL 7'h76
`define OPC_GOTO 8'hef
`define OPC_LFSR 8'hee
`define OPC_ADDC 6'h08
`define OPC_ADD 6'h09
`define OPC_SUB 6'h17
`define OPC_SUBB 6'h16
`define OPC_SUBFB 6'h15
`define OPC_OR 6'h04
`define OPC_AND 6'h05
`define OPC_XOR 6'h06
`define OPC_COM 6'h07
`define OPC_DECSZ 6'h0b
`define OPC_INCSZ 6'h0f
`define OPC_DECSNZ 6'h13
`define OPC_INCSNZ 6'h12
`define OPC_CPLT 7'h30
`define OPC_CPEQ 7'h31
`define OPC_CPGT 7'h32
`define OPC_TSTZ 7'h33
`define OPC_RLC 6'h0d
`define OPC_RRC 6'h0c
`define OPC_RLN 6'h11
`define OPC_RRN 6'h10
`define OPC_MUL 7'h01
`define OPC_BTFSC 4'hb
`define OPC_BTFSS 4'ha
`define OPC_BCF 4'h9
`define OPC_BSF 4'h8
`define OPC_BTG 4'h7
`define OP_NONE 5'h00
`define OP_ADDC 5'h01
`define OP_ADD 5'h02
`define OP_SUB 5'h03
`define OP_SUBB 5'h04
`define OP_SUBFB 5'h05
`define OP_OR 5'h06
`define OP_AND 5'h07
`define OP_XOR 5'h08
`define OP_COM 5'h09
`define OP_DECSZ 5'h0a
`define OP_INCSZ 5'h0b
`define OP_DECSNZ 5'h0c
`define OP_INCSNZ 5'h0d
`define OP_CPLT 5'h0e
`define OP_CPEQ 5'h0f
`define OP_CPGT 5'h10
`define OP_TSTZ 5'h11
`define OP_RLC 5'h12
`define OP_RRC 5'h13
`define OP_RLN 5'h14
`define OP_RRN 5'h15
`define OP_MUL 5'h16
`define OP_FILE_TO_FILE_MOVE 5'h17
`define OP_BRA 5'h18
`define OP_CBR 5'h19
`define OP_CALL 5'h1a
`define OP_GOTO 5'h1b
`define OP_BITOP 5'h1c
`define OP_BITSKIP 5'h1d
`define OP_LITERAL 5'h1e
`define FLAGS_W 5
`define FL_C 5'h01
`define FL_DC 5'h02
`define FL_Z 5'h04
`define FL_OV 5'h08
`define FL_N 5'h10
`define FL_ARITH 5'h1f
`define FL_ZN 5'h14
`define FL_CZN 5'h15
`define TIMER_ZERO_COUNT_ADDR 8'hd6
`define ACCESS_BANK 4'h0
`define BANK_W 4
`endif

// ===== verilog/opcode_classifier.v
// Combinational opcode classifier for one instruction word.
`timescale 1ns/100ps
`include "byte_op_decoder_consts.vh"
module opcode_classifier (
   input wire [`WORD_W-1:0] word_in,
   output reg [4:0] op_out,
   output reg [`FLAGS_W-1:0] flags_out,
   output reg has_dest_out,
   output reg two_word_out,
   output reg is_skip_out,
   output reg pc_mod_out,
   output reg writes_file_out
);
   always @* begin
      op_out = `OP_NONE;
      flags_out = {`FLAGS_W{1'b0}};
      has_dest_out = 1'b0;
      two_word_out = 1'b0;
      is_skip_out = 1'b0;
      pc_mod_out = 1'b0;
      writes_file_out = 1'b0;
      case (word_in[15:10])
         `OPC_ADDC: op_out = `OP_ADDC;
         `OPC_ADD: op_out = `OP_ADD;
         `OPC_SUB: op_out = `OP_SUB;
         `OPC_SUBB: op_out = `OP_SUBB;
         `OPC_SUBFB: op_out = `OP_SUBFB;
         `OPC_OR: op_out = `OP_OR;
         `OPC_AND: op_out = `OP_AND;
         `OPC_XOR: op_out = `OP_XOR;
         `OPC_COM: op_out = `OP_COM;
         `OPC_DECSZ: op_out = `OP_DECSZ;
         `OPC_INCSZ: op_out = `OP_INCSZ;
         `OPC_DECSNZ: op_out = `OP_DECSNZ;
         `OPC_INCSNZ: op_out = `OP_INCSNZ;
         `OPC_RLC: op_out = `OP_RLC;
         `OPC_RRC: op_out = `OP_RRC;
         `OPC_RLN: op_out = `OP_RLN;
         `OPC_RRN: op_out = `OP_RRN;
         default: op_out = `OP_NONE;
      endcase
      if (op_out != `OP_NONE) begin
         has_dest_out = 1'b1;
      end
      case (word_in[15:9])
         `OPC_CPLT: op_out = `OP_CPLT;
         `OPC_CPEQ: op_out = `OP_CPEQ;
         `OPC_CPGT: op_out = `OP_CPGT;
         `OPC_TSTZ: op_out = `OP_TSTZ;
         `OPC_MUL: op_out = `OP_MUL;
         `OPC_CALL: op_out = `OP_CALL;
         default: op_out = op_out;
      endcase
      if (word_in[15:8] == `OPC_GOTO) begin
         op_out = `OP_GOTO;
      end
      if (word_in[15:11] == `OPC_BRA) begin
         op_out = `OP_BRA;
      end
      if (word_in[15:11] == `OPC_COND_BR) begin
         op_out = `OP_CBR;
      end
      case (word_in[15:12])
         `OPC_FILE_TO_FILE_MOVE_FIRST: op_out = `OP_FILE_TO_FILE_MOVE;
         `OPC_BTFSC, `OPC_BTFSS: op_out = `OP_BITSKIP;
         `OPC_BCF, `OPC_BSF, `OPC_BTG: op_out = `OP_BITOP;
         default: op_out = op_out;
      endcase
      if (word_in[15:12] == 4'h0 && word_in[11] == 1'b1) begin
         op_out = `OP_LITERAL;
      end
      case (op_out)
         `OP_ADDC, `OP_ADD, `OP_SUB, `OP_SUBB, `OP_SUBFB:
            flags_out = `FL_ARITH;
         `OP_OR, `OP_AND, `OP_XOR, `OP_COM,
         `OP_RLN, `OP_RRN: flags_out = `FL_ZN;
         `OP_RLC, `OP_RRC: flags_out = `FL_CZN;
         default: flags_out = {`FLAGS_W{1'b0}};
      endcase
      case (op_out)
         `OP_DECSZ, `OP_INCSZ, `OP_DECSNZ, `OP_INCSNZ,
         `OP_CPLT, `OP_CPEQ, `OP_CPGT, `OP_TSTZ,
         `OP_BITSKIP: is_skip_out = 1'b1;
         default: is_skip_out = 1'b0;
      endcase
      two_word_out = (op_out == `OP_FILE_TO_FILE_MOVE) || (op_out == `OP_CALL) ||
         (op_out == `OP_GOTO) || (word_in[15:8] == `OPC_LFSR);
      pc_mod_out = (op_out == `OP_BRA) || (op_out == `OP_CALL) ||
         (op_out == `OP_GOTO);
      writes_file_out = (op_out == `OP_BITOP) || has_dest_out;
   end
endmodule // opcode_classifier

// ===== verif/decoder_checker.sv
// Port checker for the byte-operation instruction decoder.
`timescale 1ns/100ps
`include "byte_op_decoder_consts.vh"
module decoder_checker #(
   parameter WORD_W = 16
) (
   input wire CLOCK_IN,
   input wire RESETN_IN,
   input wire WORD_VALID_IN,
   input wire [WORD_W-1:0] WORD_IN,
   input wire SKIP_TAKEN_IN,
   input wire [3:0] BANK_SELECT_IN,
   input wire TIMER_ZERO_COUNT_PRESCALER_ASSIGNED_IN,
   input wire [4:0] OP_OUT,
   input wire OP_VALID_OUT,
   input wire NOP_CYCLE_OUT,
   input wire DEST_FILE_OUT,
   input wire [3:0] BANK_OUT,
   input wire [7:0] FILE_ADDR_OUT,
   input wire [2:0] BIT_POS_OUT,
   input wire [11:0] MOVE_SRC_OUT,
   input wire [11:0] MOVE_DST_OUT,
   input wire [10:0] BRANCH_OFS_OUT,
   input wire [4:0] FLAGS_AFFECTED_OUT,
   input wire PRESCALER_CLEAR_OUT,
   input wire BUSY_OUT
);
   reg skip_ff;
   wire tk = WORD_VALID_IN && !BUSY_OUT && !skip_ff;
   wire [15:0] w = WORD_IN[15:0];
   // A taken skip swallows the next word, so that word is no fresh issue.
   always @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) skip_ff <= 1'b0;
      else skip_ff <= tk && SKIP_TAKEN_IN;
   end
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   sequence s_mv;
      tk && w[15:12] == 4'hc ##1 WORD_VALID_IN && w[15:12] == 4'hf;
   endsequence
   sequence s_skp;
      tk && SKIP_TAKEN_IN && w[15:9] == `OPC_CPEQ ##1
      WORD_VALID_IN && w[15:8] == `OPC_GOTO;
   endsequence
   a_add_fields: assert property (
      tk && w[15:10] == `OPC_ADD |=> OP_VALID_OUT && OP_OUT == `OP_ADD &&
      FLAGS_AFFECTED_OUT == `FL_ARITH && DEST_FILE_OUT == $past(w[9]) &&
      FILE_ADDR_OUT == $past(w[7:0])) else $error("add fields wrong");
   a_bank_pick: assert property (
      tk && w[15:11] == 5'h04 |=> BANK_OUT ==
      ($past(w[8]) ? $past(BANK_SELECT_IN) : `ACCESS_BANK))
      else $error("bank choice wrong");
   a_skip_flags: assert property (
      tk && (w[15:10] == `OPC_DECSZ || w[15:9] == `OPC_TSTZ) |=>
      OP_VALID_OUT && FLAGS_AFFECTED_OUT == 5'h00)
      else $error("skip op flags wrong");
   a_move_pair: assert property (
      s_mv |=> OP_VALID_OUT && OP_OUT == 5'h17 &&
      MOVE_SRC_OUT == $past(w[11:0], 2) && MOVE_DST_OUT == $past(w[11:0]))
      else $error("move addresses wrong");
   a_branch_nop: assert property (
      tk && w[15:11] == 5'h1a |=> OP_VALID_OUT && OP_OUT == 5'h18 &&
      BRANCH_OFS_OUT == $past(w[10:0]) ##1 NOP_CYCLE_OUT && !OP_VALID_OUT)
      else $error("branch slot wrong");
   a_bit_field: assert property (
      tk && w[15:12] == `OPC_BCF |=> BIT_POS_OUT == $past(w[11:9]))
      else $error("bit position wrong");
   a_prescale_clear: assert property (
      tk && w[15:9] == 7'h13 && w[7:0] == 8'hd6 |=>
      PRESCALER_CLEAR_OUT == $past(TIMER_ZERO_COUNT_PRESCALER_ASSIGNED_IN))
      else $error("prescaler clear wrong");
   a_skip_two: assert property (
      s_skp |=> NOP_CYCLE_OUT ##1 NOP_CYCLE_OUT)
      else $error("skip slots wrong");
endmodule // decoder_checker
bind byte_op_instruction_decoder decoder_checker #(.WORD_W(WORD_W)) chk (.*);

// ===== verif/fetch_model.sv
// Fetch-side model that presents program words to the decoder.
`timescale 1ns/100ps
module fetch_model (
   input wire clk_in,
   input wire rst_n_in,
   input wire go_in,
   input wire [15:0] word_in,
   output wire valid_out,
   output wire [15:0] word_out
);
   reg [15:0] held_ff;
   // An idle bus flips every cycle, so it never repeats the last word.
   assign valid_out = go_in;
   assign word_out = go_in ? word_in : ~held_ff;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) held_ff <= 16'h0000;
      else held_ff <= word_out;
   end
endmodule // fetch_model

// ===== verif/byte_op_instruction_decoder_bench.sv
// Self-checking bench for the byte-operation instruction decoder.
`timescale 1ns/100ps
`include "byte_op_decoder_consts.vh"
module byte_op_instruction_decoder_bench;
   reg CLOCK_IN = 1'b0;
   reg RESETN_IN, SKIP_TAKEN_IN, BRANCH_TAKEN_IN, go;
   reg TIMER_ZERO_COUNT_PRESCALER_ASSIGNED_IN;
   reg [3:0] BANK_SELECT_IN;
   reg [15:0] word;
   wire [7:0] PORT_ADDR_LO_IN = 8'h80, PORT_ADDR_HI_IN = 8'h8f;
   wire WORD_VALID_IN, OP_VALID_OUT, NOP_CYCLE_OUT, DEST_FILE_OUT;
   wire READ_PINS_OUT, PRESCALER_CLEAR_OUT, BUSY_OUT;
   wire [15:0] WORD_IN;
   wire [4:0] OP_OUT, FLAGS_AFFECTED_OUT;
   wire [3:0] BANK_OUT;
   wire [7:0] FILE_ADDR_OUT, LITERAL_OUT;
   wire [2:0] BIT_POS_OUT;
   wire [11:0] MOVE_SRC_OUT, MOVE_DST_OUT;
   wire [19:0] TARGET_OUT;
   wire [10:0] BRANCH_OFS_OUT;
   integer err_total, tests_run, cyc, i;
   reg [17:0] tab [0:19];
   fetch_model fetch (.clk_in(CLOCK_IN), .rst_n_in(RESETN_IN), .go_in(go),
      .word_in(word), .valid_out(WORD_VALID_IN), .word_out(WORD_IN));
   byte_op_instruction_decoder dut (.*);
   always #5 CLOCK_IN = ~CLOCK_IN;
   // The tests need about 55 cycles; far beyond that means a hang.
   always @(posedge CLOCK_IN) begin
      cyc = cyc + 1;
      if (cyc == 600) begin
         err_total = err_total + 1;
         report_and_stop;
      end
   end
   task chk(input [31:0] seen, input [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task put(input [15:0] w, input s);
      @(negedge CLOCK_IN);
      go = 1'b1;
      word = w;
      SKIP_TAKEN_IN = s;
   endtask
   task gap;
      @(negedge CLOCK_IN);
      go = 1'b0;
      SKIP_TAKEN_IN = 1'b0;
   endtask
   task t_bytes;
      put(16'h2603, 1'b0);
      put(16'h2103, 1'b0);
      chk({OP_VALID_OUT, OP_OUT}, {1'b1, `OP_ADD});
      chk({DEST_FILE_OUT, BANK_OUT, FILE_ADDR_OUT}, 13'h1003);
      for (i = 0; i < 21; i = i + 1) begin
         if (i < 20) put({tab[i][17:10], 8'h11}, 1'b0);
         else gap;
         if (i == 0) chk({DEST_FILE_OUT, BANK_OUT, OP_OUT}, 10'h0a1);
         else chk({OP_OUT, FLAGS_AFFECTED_OUT}, tab[i-1][9:0]);
      end
      $display("byte op test done");
   endtask
   task t_pairs;
      put(16'hc123, 1'b0);
      put(16'hf456, 1'b0);
      put(16'hef12, 1'b0);
      chk({OP_VALID_OUT, OP_OUT}, {1'b1, 5'h17});
      chk({MOVE_SRC_OUT, MOVE_DST_OUT}, 24'h123456);
      put(16'hf345, 1'b0);
      gap;
      chk({OP_VALID_OUT, OP_OUT, TARGET_OUT}, {1'b1, `OP_GOTO, 20'h34512});
      gap;
      chk({OP_VALID_OUT, NOP_CYCLE_OUT}, 2'b01);
      $display("two word test done");
   endtask
   task t_flow;
      put(16'hd7ff, 1'b0);
      put(16'h2603, 1'b0);
      chk(BRANCH_OFS_OUT, 11'h7ff);
      chk(BUSY_OUT, 1'b1);
      gap;
      chk({OP_VALID_OUT, NOP_CYCLE_OUT}, 2'b01);
      put(16'he0fe, 1'b0);
      BRANCH_TAKEN_IN = 1'b1;
      gap;
      BRANCH_TAKEN_IN = 1'b0;
      chk({OP_OUT, BRANCH_OFS_OUT}, {`OP_CBR, 11'h7fe});
      gap;
      chk(NOP_CYCLE_OUT, 1'b1);
      put(16'h6200, 1'b1);
      put(16'hef00, 1'b0);
      chk({OP_VALID_OUT, OP_OUT}, {1'b1, `OP_CPEQ});
      put(16'hf000, 1'b0);
      chk({OP_VALID_OUT, NOP_CYCLE_OUT}, 2'b01);
      gap;
      chk({OP_VALID_OUT, NOP_CYCLE_OUT}, 2'b01);
      gap;
      chk({OP_VALID_OUT, NOP_CYCLE_OUT}, 2'b00);
      $display("flow test done");
   endtask
   task t_side;
      put(16'h26d6, 1'b0);
      put(16'h24d6, 1'b0);
      chk(PRESCALER_CLEAR_OUT, 1'b1);
      TIMER_ZERO_COUNT_PRESCALER_ASSIGNED_IN = 1'b0;
      put(16'h26d6, 1'b0);
      chk(PRESCALER_CLEAR_OUT, 1'b0);
      put(16'h2685, 1'b0);
      chk(PRESCALER_CLEAR_OUT, 1'b0);
      put(16'h2485, 1'b0);
      chk(READ_PINS_OUT, 1'b1);
      put(16'h0e7f, 1'b0);
      chk(READ_PINS_OUT, 1'b0);
      put(16'h9a10, 1'b0);
      chk({OP_OUT, LITERAL_OUT}, {`OP_LITERAL, 8'h7f});
      gap;
      chk({OP_OUT, BIT_POS_OUT}, {`OP_BITOP, 3'h5});
      $display("side effect test done");
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      RESETN_IN = 1'b0;
      go = 1'b0;
      word = 16'h0000;
      SKIP_TAKEN_IN = 1'b0;
      BRANCH_TAKEN_IN = 1'b0;
      TIMER_ZERO_COUNT_PRESCALER_ASSIGNED_IN = 1'b1;
      BANK_SELECT_IN = 4'h5;
      err_total = 0;
      tests_run = 0;
      cyc = 0;
      tab = '{{8'h5c, `OP_SUB, `FL_ARITH}, {8'h58, `OP_SUBB, `FL_ARITH},
         {8'h54, `OP_SUBFB, `FL_ARITH}, {8'h10, `OP_OR, `FL_ZN},
         {8'h14, `OP_AND, `FL_ZN}, {8'h18, `OP_XOR, `FL_ZN},
         {8'h1c, `OP_COM, `FL_ZN}, {8'h2c, `OP_DECSZ, 5'h00},
         {8'h3c, `OP_INCSZ, 5'h00}, {8'h4c, `OP_DECSNZ, 5'h00},
         {8'h48, `OP_INCSNZ, 5'h00}, {8'h60, `OP_CPLT, 5'h00},
         {8'h62, `OP_CPEQ, 5'h00}, {8'h64, `OP_CPGT, 5'h00},
         {8'h66, `OP_TSTZ, 5'h00}, {8'h34, `OP_RLC, `FL_CZN},
         {8'h30, `OP_RRC, `FL_CZN}, {8'h44, `OP_RLN, `FL_ZN},
         {8'h40, `OP_RRN, `FL_ZN}, {8'h02, `OP_MUL, 5'h00}};
      repeat (5) @(negedge CLOCK_IN);
      RESETN_IN = 1'b1;
      t_bytes;
      t_pairs;
      t_flow;
      t_side;
      report_and_stop;
   end
endmodule // byte_op_instruction_decoder_bench
